// ===== verilog/dofs_defs.svh
// Purpose: constants of the drive output function select block
// Assumes: frequencies in 0.01 Hz units, 100 MHz clock
// Notes: settings take their reset values until loaded
// Operation
// - desired frequency threshold 1.00-400.00 Hz; output on when reached
// - terminal count 0-999, default 0, is the counter upper limit
// - counter advances on trigger events from the counting input
// - counter at a nonzero terminal count activates terminal-count output; terminal count 0 keeps it off
// - preliminary count 0-999; a nonzero value closes output when count reaches it, 0 keeps it open
// - code 1: relay on while drive runs
// - code 2: relay on when running and output reaches setting frequency
// - code 3: relay on while command below minimum frequency
// - code 4: relay on while over-torque detected
// - code 5: relay on while output shut off by base-block
// - code 6: relay on while low voltage detected
// - code 7: relay on while controlled from external terminals
// - code 8: relay on at fault; code 8 is reset default
// - code 9: relay on when desired frequency threshold reached
// - code 10: relay on while sequence program runs
// - code 11: relay pulses 0.5 s per sequence step attained
// - code 12: relay pulses 0.5 s when sequence cycle completes
// - code 13: relay on while sequence paused
// - code 14 terminal count reached, code 15 preliminary reached
// - code 16 drive ready; code 0 unused; codes above 16 off
// - analog command is input times gain 1-200% plus signed bias
// - analog command clamps at maximum output frequency
// - each trigger event below terminal count increments the counter by exactly one
// - counter reset clears count; counting inhibited while reset held
`ifndef DOFS_DEFS_SVH
`define DOFS_DEFS_SVH
`define DOFS_THR_MIN 16'h0064
`define DOFS_THR_MAX 16'h9C40
`define DOFS_THR_RST 16'h0064
`define DOFS_CNT_MAX 10'h3E7
`define DOFS_TERM_RST 10'h000
`define DOFS_PRE_RST 10'h000
`define DOFS_SEL_RST 5'h08
`define DOFS_SEL_LAST 5'h10
`define DOFS_BIAS_MAX 16'h88B8
`define DOFS_BIAS_RST 16'h0000
`define DOFS_GAIN_RST 8'h64
`define DOFS_GAIN_MIN 8'h01
`define DOFS_GAIN_MAX 8'hC8
`define DOFS_PCT_DIV 24'h000064
`define DOFS_ADC_SHIFT 10
`define DOFS_PERMIT_RST 2'h0
`define DOFS_PERMIT_REV 2'h1
`define DOFS_PULSE_MS 500
`define DOFS_CLK_KHZ 100000
`define DOFS_PULSE_CYCLES (`DOFS_PULSE_MS * `DOFS_CLK_KHZ)
`endif

// ===== verilog/dofs_pkg.sv
// Purpose: types of the drive output function select block
// Assumes: constants live in dofs_defs.svh
// Notes: none
package dofs_pkg;
    typedef enum logic [0:0] {
        DOFS_IDLE = 1'h0,
        DOFS_HOLD = 1'h1
    } dofs_pmode_t;
    typedef struct packed {
        dofs_pmode_t mode;
        logic [25:0] cnt;
    } dofs_pulse_t;
    typedef struct packed {
        logic [15:0] thr;
        logic [9:0] term;
        logic [9:0] prelim;
        logic [4:0] sel;
        logic [15:0] bias;
        logic biasNeg;
        logic [7:0] gain;
        logic [1:0] permit;
    } dofs_cfg_t;
    typedef struct packed {
        logic running;
        logic overTorque;
        logic baseBlock;
        logic lowVoltage;
        logic extControl;
        logic fault;
        logic seqRunning;
        logic seqStep;
        logic seqCycle;
        logic seqPaused;
        logic ready;
    } dofs_status_t;
    typedef struct packed {
        dofs_cfg_t cfg;
        logic [9:0] count;
        logic trigPrev;
        logic relay;
        logic termHit;
        logic preHit;
        logic [15:0] cmd;
        logic reverse;
    } dofs_main_t;
endpackage

// ===== verilog/dofs_pulse_timer.sv
// Purpose: retriggerable one-shot that stretches an event to a pulse
// Assumes: trigger is a one-cycle event
// Notes: busy rises the cycle after trigger for PULSE_CYCLES cycles
`timescale 1ns/100ps
`include "dofs_defs.svh"
module dofs_pulse_timer #(
    parameter int unsigned PULSE_CYCLES = `DOFS_PULSE_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // event in, pulse out
    input wire logic trigger,
    output logic busy
);
    dofs_pkg::dofs_pulse_t st_ff;
    dofs_pkg::dofs_pulse_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        case (st_ff.mode)
            dofs_pkg::DOFS_IDLE: begin
                nxt_st.cnt = 26'h0000000;
            end
            dofs_pkg::DOFS_HOLD: begin
                if (st_ff.cnt == 26'h0000000) begin
                    nxt_st.mode = dofs_pkg::DOFS_IDLE;
                end else begin
                    nxt_st.cnt = st_ff.cnt - 26'h0000001;
                end
            end
            default: begin
                nxt_st.mode = dofs_pkg::DOFS_IDLE;
            end
        endcase
        if (trigger) begin
            nxt_st.mode = dofs_pkg::DOFS_HOLD;
            nxt_st.cnt = 26'(PULSE_CYCLES - 1);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_ff <= '{mode: dofs_pkg::DOFS_IDLE, cnt: 26'h0000000};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign busy = (st_ff.mode == dofs_pkg::DOFS_HOLD);
endmodule

// ===== verilog/dofs_top.sv
// Purpose: relay function select, event counter, analog command
// Assumes: all inputs synchronous to clock; settings taken on cfgLoad
// Notes: frequencies in 0.01 Hz; analog input full scale is 1023
`timescale 1ns/100ps
`include "dofs_defs.svh"
module dofs_top #(
    parameter int unsigned PULSE_CYCLES = `DOFS_PULSE_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // settings
    input wire logic cfgLoad,
    input wire dofs_pkg::dofs_cfg_t cfgIn,
    // drive status
    input wire dofs_pkg::dofs_status_t status,
    input wire logic [15:0] outFreq,
    input wire logic [15:0] cmdFreq,
    input wire logic [15:0] minFreq,
    input wire logic [15:0] maxFreq,
    // counter inputs
    input wire logic countTrigger,
    input wire logic countReset,
    // analog input
    input wire logic [9:0] analogInputLevel,
    // outputs
    output logic relayOut,
    output logic terminalCountHit,
    output logic preliminaryCountHit,
    output logic [9:0] countValue,
    output logic [15:0] analogFrequencyCommand,
    output logic analogReverse,
    output dofs_pkg::dofs_cfg_t cfgOut
);
    dofs_pkg::dofs_main_t st_ff;
    dofs_pkg::dofs_main_t nxt_st;
    logic stepBusy;
    logic cycleBusy;
    logic trigEdge;
    logic thrHit;
    logic [25:0] scaleProd;
    logic [23:0] gainProd;
    logic [23:0] pctVal;
    logic signed [18:0] biased;
    logic [17:0] magnitude;

    function automatic logic [15:0] clampTo(input logic [17:0] v,
                                            input logic [15:0] lim);
        if (v > {2'h0, lim}) begin
            clampTo = lim;
        end else begin
            clampTo = v[15:0];
        end
    endfunction

    function automatic logic [9:0] limCount(input logic [9:0] v);
        if (v > `DOFS_CNT_MAX) begin
            limCount = `DOFS_CNT_MAX;
        end else begin
            limCount = v;
        end
    endfunction

    dofs_pulse_timer #(
        .PULSE_CYCLES(PULSE_CYCLES)
    ) stepTimer (
        .clock(clock),
        .rst(rst),
        .trigger(status.seqStep),
        .busy(stepBusy)
    );

    dofs_pulse_timer #(
        .PULSE_CYCLES(PULSE_CYCLES)
    ) cycleTimer (
        .clock(clock),
        .rst(rst),
        .trigger(status.seqCycle),
        .busy(cycleBusy)
    );

    assign trigEdge = countTrigger & ~st_ff.trigPrev;
    assign thrHit = outFreq >= st_ff.cfg.thr;

    // analog command arithmetic
    assign scaleProd = analogInputLevel * maxFreq;
    assign gainProd = scaleProd[25:`DOFS_ADC_SHIFT] * st_ff.cfg.gain;
    assign pctVal = gainProd / `DOFS_PCT_DIV;
    always_comb begin
        biased = $signed({1'b0, pctVal[17:0]});
        if (st_ff.cfg.biasNeg) begin
            biased = biased - $signed({3'h0, st_ff.cfg.bias});
        end else begin
            biased = biased + $signed({3'h0, st_ff.cfg.bias});
        end
        if (biased < 0) begin
            magnitude = 18'(-biased);
        end else begin
            magnitude = biased[17:0];
        end
    end

    always_comb begin
        nxt_st = st_ff;
        if (cfgLoad) begin
            nxt_st.cfg = cfgIn;
            nxt_st.cfg.term = limCount(cfgIn.term);
            nxt_st.cfg.prelim = limCount(cfgIn.prelim);
            if (cfgIn.thr < `DOFS_THR_MIN) begin
                nxt_st.cfg.thr = `DOFS_THR_MIN;
            end else if (cfgIn.thr > `DOFS_THR_MAX) begin
                nxt_st.cfg.thr = `DOFS_THR_MAX;
            end
            if (cfgIn.bias > `DOFS_BIAS_MAX) begin
                nxt_st.cfg.bias = `DOFS_BIAS_MAX;
            end
            if (cfgIn.gain < `DOFS_GAIN_MIN) begin
                nxt_st.cfg.gain = `DOFS_GAIN_MIN;
            end else if (cfgIn.gain > `DOFS_GAIN_MAX) begin
                nxt_st.cfg.gain = `DOFS_GAIN_MAX;
            end
        end
        nxt_st.trigPrev = countTrigger;
        // event counter
        if (countReset) begin
            nxt_st.count = 10'h000;
        end else if (trigEdge && st_ff.count < st_ff.cfg.term) begin
            nxt_st.count = st_ff.count + 10'h001;
        end
        nxt_st.termHit = (st_ff.cfg.term != 10'h000) &&
            (st_ff.count >= st_ff.cfg.term);
        nxt_st.preHit = (st_ff.cfg.prelim != 10'h000) &&
            (st_ff.count >= st_ff.cfg.prelim);
        // relay function select
        case (st_ff.cfg.sel)
            5'h00: nxt_st.relay = 1'b0;
            5'h01: nxt_st.relay = status.running;
            5'h02: nxt_st.relay = status.running &&
                (outFreq == cmdFreq);
            5'h03: nxt_st.relay = cmdFreq < minFreq;
            5'h04: nxt_st.relay = status.overTorque;
            5'h05: nxt_st.relay = status.baseBlock;
            5'h06: nxt_st.relay = status.lowVoltage;
            5'h07: nxt_st.relay = status.extControl;
            5'h08: nxt_st.relay = status.fault;
            5'h09: nxt_st.relay = thrHit;
            5'h0A: nxt_st.relay = status.seqRunning;
            5'h0B: nxt_st.relay = stepBusy;
            5'h0C: nxt_st.relay = cycleBusy;
            5'h0D: nxt_st.relay = status.seqPaused;
            5'h0E: nxt_st.relay = st_ff.termHit;
            5'h0F: nxt_st.relay = st_ff.preHit;
            5'h10: nxt_st.relay = status.ready;
            default: nxt_st.relay = 1'b0;
        endcase
        // analog command with clamp
        if (biased < 0) begin
            if (st_ff.cfg.permit == `DOFS_PERMIT_REV) begin
                nxt_st.cmd = clampTo(magnitude, maxFreq);
                nxt_st.reverse = 1'b1;
            end else begin
                nxt_st.cmd = 16'h0000;
                nxt_st.reverse = 1'b0;
            end
        end else begin
            nxt_st.cmd = clampTo(magnitude, maxFreq);
            nxt_st.reverse = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_ff.cfg.thr <= `DOFS_THR_RST;
            st_ff.cfg.term <= `DOFS_TERM_RST;
            st_ff.cfg.prelim <= `DOFS_PRE_RST;
            st_ff.cfg.sel <= `DOFS_SEL_RST;
            st_ff.cfg.bias <= `DOFS_BIAS_RST;
            st_ff.cfg.biasNeg <= 1'b0;
            st_ff.cfg.gain <= `DOFS_GAIN_RST;
            st_ff.cfg.permit <= `DOFS_PERMIT_RST;
            st_ff.count <= 10'h000;
            st_ff.trigPrev <= 1'b0;
            st_ff.relay <= 1'b0;
            st_ff.termHit <= 1'b0;
            st_ff.preHit <= 1'b0;
            st_ff.cmd <= 16'h0000;
            st_ff.reverse <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign relayOut = st_ff.relay;
    assign terminalCountHit = st_ff.termHit;
    assign preliminaryCountHit = st_ff.preHit;
    assign countValue = st_ff.count;
    assign analogFrequencyCommand = st_ff.cmd;
    assign analogReverse = st_ff.reverse;
    assign cfgOut = st_ff.cfg;

    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    AST_THR_RELAY: assert property (
        st_ff.cfg.sel == 5'h09 && outFreq >= st_ff.cfg.thr &&
        !cfgLoad |=> relayOut)
        else $error("threshold reached but relay off");
    AST_RUN_RELAY: assert property (
        st_ff.cfg.sel == 5'h01 && !cfgLoad |=>
        relayOut == $past(status.running))
        else $error("run relay mismatch");
    AST_ZERO_SPD: assert property (
        st_ff.cfg.sel == 5'h03 && !cfgLoad |=>
        relayOut == ($past(cmdFreq) < $past(minFreq)))
        else $error("zero speed relay mismatch");
    AST_FAULT_RELAY: assert property (
        st_ff.cfg.sel == 5'h08 && !cfgLoad |=>
        relayOut == $past(status.fault))
        else $error("fault relay mismatch");
    AST_STEP_PULSE: assert property (
        status.seqStep |=> stepBusy [*8])
        else $error("step pulse too short");
    AST_CYCLE_PULSE: assert property (
        status.seqCycle |=> cycleBusy [*8])
        else $error("cycle pulse too short");
    AST_UNDEF_SEL: assert property (
        st_ff.cfg.sel > `DOFS_SEL_LAST && !cfgLoad |=> !relayOut)
        else $error("undefined code drives relay");
    AST_CNT_INC: assert property (
        trigEdge && !countReset && countValue < st_ff.cfg.term &&
        !cfgLoad |=> countValue == $past(countValue) + 10'h001)
        else $error("count did not advance by one");
    AST_CNT_CLR: assert property (
        countReset [*2] |-> countValue == 10'h000)
        else $error("count not cleared");
    AST_CNT_HOLD: assert property (
        !countReset && countValue >= st_ff.cfg.term |=>
        countValue == $past(countValue))
        else $error("count moved past terminal");
    AST_TERM_HIT: assert property (
        st_ff.cfg.term != 10'h000 && countValue == st_ff.cfg.term &&
        !cfgLoad |=> terminalCountHit)
        else $error("terminal count not flagged");
    AST_PRE_HIT: assert property (
        st_ff.cfg.prelim != 10'h000 && countValue >= st_ff.cfg.prelim &&
        !cfgLoad |=> preliminaryCountHit)
        else $error("preliminary count not flagged");
    AST_CLAMP: assert property (
        !rst |=> analogFrequencyCommand <= $past(maxFreq))
        else $error("analog command above maximum");

    AST_SET_FREQ: assert property (
        st_ff.cfg.sel == 5'h02 |=>
        relayOut == ($past(status.running) &&
        $past(outFreq) == $past(cmdFreq)))
        else $error("setting frequency relay mismatch");
    AST_TORQUE: assert property (
        st_ff.cfg.sel == 5'h04 |=>
        relayOut == $past(status.overTorque))
        else $error("over-torque relay mismatch");
    AST_BASE_BLOCK: assert property (
        st_ff.cfg.sel == 5'h05 |=>
        relayOut == $past(status.baseBlock))
        else $error("base-block relay mismatch");
    AST_LOW_VOLT: assert property (
        st_ff.cfg.sel == 5'h06 |=>
        relayOut == $past(status.lowVoltage))
        else $error("low voltage relay mismatch");
    AST_EXT_CTRL: assert property (
        st_ff.cfg.sel == 5'h07 |=>
        relayOut == $past(status.extControl))
        else $error("external control relay mismatch");
    AST_SEQ_RUN: assert property (
        st_ff.cfg.sel == 5'h0A |=>
        relayOut == $past(status.seqRunning))
        else $error("sequence running relay mismatch");
    AST_STEP_RELAY: assert property (
        st_ff.cfg.sel == 5'h0B |=>
        relayOut == $past(stepBusy))
        else $error("step pulse relay mismatch");
    AST_CYCLE_RELAY: assert property (
        st_ff.cfg.sel == 5'h0C |=>
        relayOut == $past(cycleBusy))
        else $error("cycle pulse relay mismatch");
    AST_SEQ_PAUSE: assert property (
        st_ff.cfg.sel == 5'h0D |=>
        relayOut == $past(status.seqPaused))
        else $error("sequence paused relay mismatch");
    AST_TERM_RELAY: assert property (
        st_ff.cfg.sel == 5'h0E |=>
        relayOut == $past(terminalCountHit))
        else $error("terminal count relay mismatch");
    AST_PRE_RELAY: assert property (
        st_ff.cfg.sel == 5'h0F |=>
        relayOut == $past(preliminaryCountHit))
        else $error("preliminary count relay mismatch");
    AST_READY: assert property (
        st_ff.cfg.sel == 5'h10 |=>
        relayOut == $past(status.ready))
        else $error("ready relay mismatch");
    AST_NO_FUNC: assert property (
        st_ff.cfg.sel == 5'h00 |=>
        !relayOut)
        else $error("unused relay driven");

    AST_THR_LOAD: assert property (
        cfgLoad |=> cfgOut.thr >= `DOFS_THR_MIN &&
        cfgOut.thr <= `DOFS_THR_MAX)
        else $error("threshold outside its range");
    AST_CNT_LOAD: assert property (
        cfgLoad |=> cfgOut.term <= `DOFS_CNT_MAX &&
        cfgOut.prelim <= `DOFS_CNT_MAX)
        else $error("count setting above its limit");
    AST_GAIN_LOAD: assert property (
        cfgLoad |=> cfgOut.gain >= `DOFS_GAIN_MIN &&
        cfgOut.gain <= `DOFS_GAIN_MAX && cfgOut.bias <= `DOFS_BIAS_MAX)
        else $error("gain or bias outside its range");

    AST_NO_EDGE: assert property (
        !trigEdge && !countReset |=>
        countValue == $past(countValue))
        else $error("count moved without a trigger event");
    AST_CNT_INHIBIT: assert property (
        countReset |=> countValue == 10'h000)
        else $error("count not held clear");

    AST_REV_PERMIT: assert property (
        st_ff.cfg.permit != `DOFS_PERMIT_REV |=> !analogReverse)
        else $error("reverse without permit");
    AST_CMD_ZERO: assert property (
        analogInputLevel == 10'h000 && st_ff.cfg.bias == 16'h0000 |=>
        analogFrequencyCommand == 16'h0000)
        else $error("command not zero at zero input");

    COV_TERM: cover property (
        st_ff.cfg.sel == 5'h0E ##1 relayOut);
    COV_STEP: cover property (
        st_ff.cfg.sel == 5'h0B && status.seqStep ##2 relayOut);
    COV_CLAMP: cover property (
        analogFrequencyCommand == maxFreq && maxFreq != 16'h0000);
    COV_REV: cover property (analogReverse);
    COV_PRE: cover property (
        st_ff.cfg.sel == 5'h0F ##1 relayOut);
endmodule

// ===== tb/dofs_ext_switch.sv
// Purpose: external switch gear on the counting terminals
// Assumes: fire and clear are driven by the bench on the falling edge
// Notes: each event is high one cycle, then low at least one cycle
`timescale 1ns/100ps
module dofs_ext_switch (
    // clock
    input wire logic clock,
    // requests
    input wire logic fire,
    input wire logic clear,
    // terminals
    output logic countTrigger,
    output logic countReset
);
    initial begin
        countTrigger = 1'b0;
        countReset = 1'b0;
    end
    // one event per request, spaced by a low cycle
    always @(negedge clock) begin
        countTrigger <= fire & ~countTrigger;
        countReset <= clear;
    end
endmodule

// ===== tb/dofs_top_tb.sv
// Purpose: self-checking bench of the output function select block
// Assumes: pulse length shortened to PULSE cycles
// Notes: expected results queued by the driver, compared by a monitor
`timescale 1ns/100ps
module dofs_top_tb;
    localparam int PULSE = 20;
    typedef struct packed {
        logic relay;
        logic term;
        logic pre;
        logic [9:0] cnt;
        logic [15:0] cmd;
        logic rev;
    } dofs_exp_t;
    logic clock = 1'b0;
    logic rst, cfgLoad, fire, clear, probe;
    logic countTrigger, countReset;
    dofs_pkg::dofs_cfg_t cfg, c, cfgOut;
    dofs_pkg::dofs_status_t status;
    logic [15:0] outFreq, cmdFreq, minFreq, maxFreq, cmd;
    logic [9:0] level, countValue;
    logic relayOut, termHit, preHit, rev;
    logic mt, mp, mrev;
    logic [9:0] mc;
    logic [15:0] mcmd;
    dofs_exp_t q[$];
    dofs_exp_t e;
    int errors, check_count, i, k, n, w, v;

    dofs_top #(.PULSE_CYCLES(PULSE)) i_dofs_top (.clock(clock), .rst(rst),
        .cfgLoad(cfgLoad), .cfgIn(cfg), .status(status), .outFreq(outFreq),
        .cmdFreq(cmdFreq), .minFreq(minFreq), .maxFreq(maxFreq),
        .countTrigger(countTrigger), .countReset(countReset),
        .analogInputLevel(level), .relayOut(relayOut),
        .terminalCountHit(termHit), .preliminaryCountHit(preHit),
        .countValue(countValue), .analogFrequencyCommand(cmd),
        .analogReverse(rev), .cfgOut(cfgOut));
    dofs_ext_switch i_dofs_ext_switch (.clock(clock), .fire(fire),
        .clear(clear), .countTrigger(countTrigger),
        .countReset(countReset));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic check(input logic [31:0] x, input logic [31:0] a,
        input string s);
        check_count++;
        if (a !== x) begin
            errors++;
            $display("ERROR t=%0t %s exp %0h got %0h", $time, s, x, a);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    function automatic logic relay_of(input logic [4:0] s);
        case (s)
            5'h01: return status.running;
            5'h02: return status.running && outFreq == cmdFreq;
            5'h03: return cmdFreq < minFreq;
            5'h04: return status.overTorque;
            5'h05: return status.baseBlock;
            5'h06: return status.lowVoltage;
            5'h07: return status.extControl;
            5'h08: return status.fault;
            5'h09: return outFreq >= cfg.thr;
            5'h0A: return status.seqRunning;
            5'h0D: return status.seqPaused;
            5'h0E: return mt;
            5'h0F: return mp;
            5'h10: return status.ready;
            default: return 1'b0;
        endcase
    endfunction

    task automatic load(input dofs_pkg::dofs_cfg_t x);
        @(negedge clock);
        cfg <= x;
        cfgLoad <= 1'b1;
        @(negedge clock);
        cfgLoad <= 1'b0;
    endtask

    task automatic note(input logic r);
        @(negedge clock);
        q.push_back(dofs_exp_t'({r, mt, mp, mc, mcmd, mrev}));
        probe <= 1'b1;
        @(negedge clock);
        probe <= 1'b0;
    endtask

    task automatic fire_evt;
        @(negedge clock);
        fire <= 1'b1;
        @(negedge clock);
        fire <= 1'b0;
        repeat (3) @(negedge clock);
        mt = (mc >= 10'h003);
        mp = (mc >= 10'h002);
    endtask

    // monitor: each probed edge takes the oldest note
    always @(posedge clock) begin
        if (probe) begin
            #1;
            if (q.size() == 0) begin
                check(1, 0, "queue empty");
            end else begin
                e = q.pop_front();
                check(e.relay, relayOut, "relay");
                check(e.term, termHit, "term hit");
                check(e.pre, preHit, "pre hit");
                check(e.cnt, countValue, "count");
                check(e.cmd, cmd, "command");
                check(e.rev, rev, "reverse");
            end
        end
    end

    initial begin
        #900000;
        errors++;
        final_report();
    end

    initial begin
        rst = 1'b1;
        cfgLoad = 1'b0;
        cfg = '0;
        status = '0;
        outFreq = '0;
        cmdFreq = '0;
        minFreq = '0;
        maxFreq = 16'h9C40;
        level = '0;
        fire = 1'b0;
        clear = 1'b0;
        probe = 1'b0;
        {mt, mp, mrev, mc, mcmd} = '0;
        i = $urandom(82);
        repeat (2) @(negedge clock);
        rst <= 1'b0;
        @(negedge clock);
        check(cfgOut.sel, 5'h08, "default select");
        check(cfgOut.term, 10'h000, "default term");
        check(cfgOut.thr, 16'h0064, "default threshold");
        c = cfgOut;
        for (i = 0; i < 18; i++) begin
            @(negedge clock);
            status <= dofs_pkg::dofs_status_t'(11'($urandom) & 11'h7F3);
            v = $urandom;
            outFreq <= 16'(v);
            cmdFreq <= ($urandom_range(1) == 0) ? 16'(v) : 16'($urandom);
            minFreq <= 16'($urandom);
            c.sel = 5'(i);
            c.thr = 16'h0064 + 16'($urandom_range(39900));
            load(c);
            note(relay_of(5'(i)));
        end
        $display("test relay codes done");
        for (k = 11; k < 13; k++) begin
            c.sel = 5'(k);
            load(c);
            @(negedge clock);
            status <= dofs_pkg::dofs_status_t'((k == 11) ? 11'h008 : 11'h004);
            @(negedge clock);
            status <= '0;
            n = 0;
            w = 0;
            while (relayOut !== 1'b1 && w < 10) begin
                @(negedge clock);
                w++;
            end
            while (relayOut === 1'b1 && n < 100) begin
                @(negedge clock);
                n++;
            end
            check(PULSE, n, "pulse length");
            if (w == 10 || n == 100) begin
                errors++;
                final_report();
            end
        end
        $display("test pulses done");
        c.sel = 5'h0E;
        c.term = 10'h003;
        c.prelim = 10'h002;
        load(c);
        for (k = 1; k < 6; k++) begin
            mc = (k > 3) ? 10'h003 : 10'(k);
            fire_evt();
            note(mt);
        end
        c.sel = 5'h0F;
        load(c);
        note(mp);
        @(negedge clock);
        clear <= 1'b1;
        repeat (2) @(negedge clock);
        mc = 10'h000;
        fire_evt();
        note(1'b0);
        @(negedge clock);
        clear <= 1'b0;
        repeat (2) @(negedge clock);
        mc = 10'h001;
        fire_evt();
        note(1'b0);
        $display("test counter done");
        for (k = 0; k < 8; k++) begin
            @(negedge clock);
            level <= (k == 0) ? 10'h3FF : 10'($urandom);
            c.gain = (k == 0) ? 8'hC8 : 8'($urandom_range(200, 1));
            c.bias = (k == 0) ? 16'h0000 : 16'($urandom_range(35000));
            c.biasNeg = 1'($urandom);
            c.permit = 2'($urandom_range(2));
            load(c);
            v = ((int'(level) * 40000) >> 10) * int'(c.gain) / 100;
            v = c.biasNeg ? v - int'(c.bias) : v + int'(c.bias);
            mrev = (v < 0) && (c.permit == 2'h1);
            v = (v < 0) ? (mrev ? -v : 0) : v;
            mcmd = (v > 40000) ? 16'h9C40 : 16'(v);
            note(1'b0);
        end
        c.thr = 16'hFFFF;
        c.term = 10'h3FF;
        c.gain = 8'hFF;
        c.bias = 16'hFFFF;
        load(c);
        check(cfgOut.thr, 16'h9C40, "threshold clamp");
        check(cfgOut.term, 10'h3E7, "terminal clamp");
        check(cfgOut.gain, 8'hC8, "gain clamp");
        check(cfgOut.bias, 16'h88B8, "bias clamp");
        c.thr = 16'h0000;
        c.gain = 8'h00;
        load(c);
        check(cfgOut.thr, 16'h0064, "threshold floor");
        check(cfgOut.gain, 8'h01, "gain floor");
        $display("test analog done");
        final_report();
    end
endmodule
